// file: core/dmz_params.svh
// constants for the mode register zero burst and latency block
`ifndef DMZ_PARAMS_SVH
`define DMZ_PARAMS_SVH

// ---------------------------------------------
// mode register fields
// ---------------------------------------------
`define DMZ_MR_RST       13'h0000
`define DMZ_BL_LSB       0
`define DMZ_BL_MSB       1
`define DMZ_BT_BIT       3
`define DMZ_CL_LSB       4
`define DMZ_CL_MSB       6
`define DMZ_DLLRST_BIT   8
`define DMZ_DLLRST_MASK  13'h0100
`define DMZ_WR_LSB       9
`define DMZ_WR_MSB       11
`define DMZ_AP_BIT       10
`define DMZ_PPD_BIT      12
`define DMZ_BC_BIT       12
`define DMZ_BL_FIX8      2'h0
`define DMZ_BL_OTF       2'h1
`define DMZ_BL_FIX4      2'h2

// ---------------------------------------------
// command codes {cs_n, ras_n, cas_n, we_n}
// ---------------------------------------------
`define DMZ_CMD_MRS      4'h0
`define DMZ_CMD_WR       4'h4
`define DMZ_CMD_RD       4'h5
`define DMZ_BA_MR0       3'h0

// ---------------------------------------------
// timing in link clocks
// ---------------------------------------------
`define DMZ_CL_BASE      5'h04
`define DMZ_WR_TABLE     32'hECA87655
`define DMZ_CWL          5'h05
`define DMZ_AL_M1        2'h1
`define DMZ_AL_M2        2'h2
`define DMZ_AL_OFS1      5'h01
`define DMZ_AL_OFS2      5'h02
`define DMZ_RP_CYC       5'h01
`define DMZ_LOCK_CYC     10'h200
`define DMZ_XP_CYC       5'h03
`define DMZ_XPDLL_CYC    5'h0A
`define DMZ_LAT_LAST     5'h01
`define DMZ_BEAT_FIRST   3'h0
`define DMZ_BEAT_STEP    3'h1
`define DMZ_BEAT_LAST    3'h7
`define DMZ_CHOP_PULL    3'h2
`define DMZ_DEPTH        8

// ---------------------------------------------
// register map and bus answers
// ---------------------------------------------
`define DMZ_A_MODE       4'h0
`define DMZ_A_CTRL       4'h4
`define DMZ_A_STAT       4'h8
`define DMZ_A_LAT        4'hC
`define DMZ_CTRL_RST     2'h0
`define DMZ_RESP_OK      2'h0
`define DMZ_RESP_ERR     2'h2

`endif

// file: core/dmz_pkg.sv
// types for the mode register zero burst and latency block
package dmz_pkg;
	typedef enum logic [4:0] {
		DMZ_ST_IDLE     = 5'h01,
		DMZ_ST_RD_WAIT  = 5'h02,
		DMZ_ST_RD_BURST = 5'h04,
		DMZ_ST_WR_WAIT  = 5'h08,
		DMZ_ST_WR_BURST = 5'h10
	} dmz_state_t;
endpackage

// file: core/dmz_beat_order.sv
// column index of one read beat from start column, beat and burst type
`timescale 1ns/1ps
module dmz_beat_order (
	// burst setup
	input  logic [2:0] start,
	input  logic       interleave,
	input  logic       chop,
	// beat in and column out
	input  logic [2:0] beat,
	output logic [2:0] idx
);
	// ---------------------------------------------
	// order within the group of four
	// ---------------------------------------------
	// type selects order
	wire [1:0] lo_seq = start[1:0] + beat[1:0];
	wire [1:0] lo_int = start[1:0] ^ beat[1:0];
	wire [1:0] lo     = interleave ? lo_int : lo_seq;
	wire       hi     = chop ? start[2] : start[2] ^ beat[2];

	assign idx = {hi, lo};
endmodule

// file: core/dmz_core.sv
// mode register zero decoder, burst engine and register slave
`timescale 1ns/1ps
`include "dmz_params.svh"
module dmz_core (
	// clock and reset
	input  logic        clk,
	input  logic        rst,
	// link command pins
	input  logic        ck,
	input  logic        cke,
	input  logic        cs_n,
	input  logic        ras_n,
	input  logic        cas_n,
	input  logic        we_n,
	input  logic [2:0]  ba,
	input  logic [12:0] addr,
	// data and strobe pins
	input  logic [7:0]  dq_in,
	output logic [7:0]  dq_out,
	output logic        dq_oe_n,
	output logic        dqs_out,
	output logic        dqs_oe_n,
	output logic        dll_run,
	// register bus write
	input  logic        s_axi_awvalid,
	output logic        s_axi_awready,
	input  logic [3:0]  s_axi_awaddr,
	input  logic        s_axi_wvalid,
	output logic        s_axi_wready,
	input  logic [31:0] s_axi_wdata,
	input  logic [3:0]  s_axi_wstrb,
	output logic        s_axi_bvalid,
	input  logic        s_axi_bready,
	output logic [1:0]  s_axi_bresp,
	// register bus read
	input  logic        s_axi_arvalid,
	output logic        s_axi_arready,
	input  logic [3:0]  s_axi_araddr,
	output logic        s_axi_rvalid,
	input  logic        s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0]  s_axi_rresp
);
	// ---------------------------------------------
	// pin synchronisers
	// ---------------------------------------------
	logic [29:0] s1_q;
	logic [29:0] s2_q;
	logic        ck_prev_q;

	always_ff @(posedge clk) begin
		s1_q <= {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_in};
		s2_q <= s1_q;
	end

	// starts high so a link clock already high is no edge
	always_ff @(posedge clk) begin
		if (rst)
			ck_prev_q <= 1'b1;
		else
			ck_prev_q <= s2_q[29];
	end

	wire        ck_s    = s2_q[29];
	wire        cke_s   = s2_q[28];
	wire [3:0]  cmd_s   = s2_q[27:24];
	wire [2:0]  ba_s    = s2_q[23:21];
	wire [12:0] a_s     = s2_q[20:8];
	wire [7:0]  dq_s    = s2_q[7:0];
	wire        ck_rise = ck_s & ~ck_prev_q;

	// ---------------------------------------------
	// state
	// ---------------------------------------------
	dmz_pkg::dmz_state_t st_q, st_d;
	logic [12:0] mode_q;
	logic [1:0]  ctrl_q;
	logic [4:0]  lat_q;
	logic [2:0]  beat_q;
	logic [2:0]  col_q;
	logic        chop_q;
	logic        fix_q;
	logic        ap_q;
	logic [4:0]  recov_q;
	logic [9:0]  lock_q;
	logic        pd_q;
	logic [4:0]  exit_q;
	logic        dll_run_q;
	logic [7:0]  mem_q [`DMZ_DEPTH];
	logic [7:0]  dq_out_q;
	logic        dq_oe_n_q;
	logic        dqs_out_q;

	// ---------------------------------------------
	// mode field decode
	// ---------------------------------------------
	wire [1:0]  bl_field = mode_q[`DMZ_BL_MSB:`DMZ_BL_LSB];
	wire        bt_intlv = mode_q[`DMZ_BT_BIT];
	wire [2:0]  cl_code  = mode_q[`DMZ_CL_MSB:`DMZ_CL_LSB];
	wire [4:0]  cl_cyc   = {2'h0, cl_code} + `DMZ_CL_BASE;
	wire [31:0] wr_tbl   = `DMZ_WR_TABLE;
	wire [2:0]  wr_code  = mode_q[`DMZ_WR_MSB:`DMZ_WR_LSB];
	wire [4:0]  wr_cyc   = {1'b0, wr_tbl[{wr_code, 2'h0} +: 4]};
	wire [4:0]  al_cyc   = (ctrl_q == `DMZ_AL_M1) ? cl_cyc - `DMZ_AL_OFS1 :
	                       (ctrl_q == `DMZ_AL_M2) ? cl_cyc - `DMZ_AL_OFS2 : 5'h00;
	// total is additive plus command latency
	wire [4:0]  rl_total = al_cyc + cl_cyc;
	wire [4:0]  wl_total = al_cyc + `DMZ_CWL;
	wire        bl_fix4  = (bl_field == `DMZ_BL_FIX4);
	wire        bl_otf   = (bl_field == `DMZ_BL_OTF);
	wire        cmd_chop = bl_fix4 | (bl_otf & ~a_s[`DMZ_BC_BIT]);

	// ---------------------------------------------
	// command decode
	// ---------------------------------------------
	wire st_idle  = (st_q == dmz_pkg::DMZ_ST_IDLE);
	wire st_rdw   = (st_q == dmz_pkg::DMZ_ST_RD_WAIT);
	wire st_rdb   = (st_q == dmz_pkg::DMZ_ST_RD_BURST);
	wire st_wrw   = (st_q == dmz_pkg::DMZ_ST_WR_WAIT);
	wire st_wrb   = (st_q == dmz_pkg::DMZ_ST_WR_BURST);
	wire live     = ck_rise & cke_s & ~pd_q & st_idle;
	wire take_mrs = live & (cmd_s == `DMZ_CMD_MRS) & (ba_s == `DMZ_BA_MR0);
	wire take_rd  = live & (cmd_s == `DMZ_CMD_RD);
	wire take_wr  = live & (cmd_s == `DMZ_CMD_WR);

	// ---------------------------------------------
	// burst sequencing
	// ---------------------------------------------
	wire       lat_end  = (lat_q == `DMZ_LAT_LAST);
	wire       beat_end = (beat_q == `DMZ_BEAT_LAST);
	wire       enter_rd = ck_rise & st_rdw & lat_end;
	wire       cont_rd  = ck_rise & st_rdb & ~beat_end;
	wire       enter_wr = ck_rise & st_wrw & lat_end;
	wire       cont_wr  = ck_rise & st_wrb & ~beat_end;
	wire       adv      = enter_rd | cont_rd | enter_wr | cont_wr;
	wire [2:0] nb       = (enter_rd | enter_wr) ? `DMZ_BEAT_FIRST : beat_q + `DMZ_BEAT_STEP;
	wire       waiting  = st_rdw | st_wrw;

	always_comb begin
		st_d = st_q;
		case (st_q)
			dmz_pkg::DMZ_ST_IDLE: begin
				if (take_rd)
					st_d = dmz_pkg::DMZ_ST_RD_WAIT;
				else if (take_wr)
					st_d = dmz_pkg::DMZ_ST_WR_WAIT;
			end
			dmz_pkg::DMZ_ST_RD_WAIT: begin
				if (enter_rd)
					st_d = dmz_pkg::DMZ_ST_RD_BURST;
			end
			dmz_pkg::DMZ_ST_RD_BURST: begin
				if (ck_rise && beat_end)
					st_d = dmz_pkg::DMZ_ST_IDLE;
			end
			dmz_pkg::DMZ_ST_WR_WAIT: begin
				if (enter_wr)
					st_d = dmz_pkg::DMZ_ST_WR_BURST;
			end
			dmz_pkg::DMZ_ST_WR_BURST: begin
				if (ck_rise && beat_end)
					st_d = dmz_pkg::DMZ_ST_IDLE;
			end
			default: st_d = dmz_pkg::DMZ_ST_IDLE;
		endcase
	end

	wire [4:0] lat_d = take_rd ? rl_total :
	                   take_wr ? wl_total :
	                   (ck_rise & waiting & ~lat_end) ? lat_q - `DMZ_LAT_LAST : lat_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q   <= dmz_pkg::DMZ_ST_IDLE;
			lat_q  <= 5'h00;
			beat_q <= `DMZ_BEAT_FIRST;
		end else begin
			st_q   <= st_d;
			lat_q  <= lat_d;
			beat_q <= adv ? nb : beat_q;
		end
	end

	// burst setup latched with the command
	always_ff @(posedge clk) begin
		if (rst) begin
			col_q  <= 3'h0;
			chop_q <= 1'b0;
			fix_q  <= 1'b0;
			ap_q   <= 1'b0;
		end else if (take_rd || take_wr) begin
			col_q  <= a_s[2:0];
			chop_q <= cmd_chop;
			fix_q  <= bl_fix4;
			ap_q   <= a_s[`DMZ_AP_BIT];
		end
	end

	// ---------------------------------------------
	// read data path
	// ---------------------------------------------
	wire [2:0] ord_idx;

	dmz_beat_order u_order (
		.start      (col_q),
		.interleave (bt_intlv),
		.chop       (chop_q),
		.beat       (nb),
		.idx        (ord_idx)
	);

	wire drive_rd = enter_rd | cont_rd;
	// upper four slots released on chop
	wire slot_on  = drive_rd & ~(chop_q & nb[2]);

	always_ff @(posedge clk) begin
		if (rst) begin
			dq_out_q  <= 8'h00;
			dq_oe_n_q <= 1'b1;
			dqs_out_q <= 1'b0;
		end else if (ck_rise) begin
			dq_out_q  <= slot_on ? mem_q[ord_idx] : 8'h00;
			dq_oe_n_q <= ~slot_on;
			dqs_out_q <= slot_on & ~nb[0];
		end
	end

	// ---------------------------------------------
	// write capture
	// ---------------------------------------------
	wire       cap_wr = enter_wr | cont_wr;
	// ascending fill, chop picks group by bit two
	wire [2:0] wr_idx = chop_q ? {col_q[2], nb[1:0]} : nb;
	wire       store  = cap_wr & ~(chop_q & nb[2]);

	genvar gi;
	for (gi = 0; gi < `DMZ_DEPTH; gi++) begin : g_mem
		always_ff @(posedge clk) begin
			if (rst)
				mem_q[gi] <= 8'h00;
			else if (store && wr_idx == 3'(gi))
				mem_q[gi] <= dq_s;
		end
	end

	// fixed chop pulls the internal write in
	// per-command chop keeps the eight-beat point
	wire [2:0] start_beat = fix_q ? `DMZ_BEAT_LAST - `DMZ_CHOP_PULL : `DMZ_BEAT_LAST;
	wire       wr_start   = cap_wr & (nb == start_beat);
	wire [4:0] dal_cyc    = wr_cyc + (ap_q ? `DMZ_RP_CYC : 5'h00);
	wire [4:0] recov_d    = wr_start ? dal_cyc :
	                        (ck_rise & (recov_q != 5'h00)) ? recov_q - `DMZ_LAT_LAST : recov_q;

	// ---------------------------------------------
	// mode register, loop reset, power-down
	// ---------------------------------------------
	// reset bit clears at the next link edge
	wire dll_clear = ck_rise & mode_q[`DMZ_DLLRST_BIT];
	// written only from idle with clock enable high
	wire [12:0] mode_d = take_mrs ? a_s : dll_clear ? (mode_q & ~`DMZ_DLLRST_MASK) : mode_q;
	wire [9:0]  lock_d = dll_clear ? `DMZ_LOCK_CYC :
	                     (ck_rise & (lock_q != 10'h000)) ? lock_q - 10'h001 : lock_q;
	wire pd_enter = ck_rise & ~cke_s & ~pd_q & st_idle;
	wire pd_exit  = ck_rise & cke_s & pd_q;
	wire fast     = mode_q[`DMZ_PPD_BIT];
	wire dll_run_d = pd_enter ? fast : (pd_exit | dll_run_q);
	wire [4:0] exit_d = pd_exit ? (fast ? `DMZ_XP_CYC : `DMZ_XPDLL_CYC) :
	                    (ck_rise & (exit_q != 5'h00)) ? exit_q - `DMZ_LAT_LAST : exit_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q    <= `DMZ_MR_RST;
			lock_q    <= 10'h000;
			pd_q      <= 1'b0;
			dll_run_q <= 1'b1;
			exit_q    <= 5'h00;
			recov_q   <= 5'h00;
		end else begin
			mode_q    <= mode_d;
			lock_q    <= lock_d;
			pd_q      <= pd_enter | (pd_q & ~pd_exit);
			dll_run_q <= dll_run_d;
			exit_q    <= exit_d;
			recov_q   <= recov_d;
		end
	end

	// ---------------------------------------------
	// register slave
	// ---------------------------------------------
	logic        awready_q, aw_full_q, wready_q, w_full_q;
	logic [3:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic        w_strb0_q;
	logic        bvalid_q, arready_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;

	wire aw_take   = s_axi_awvalid & awready_q;
	wire w_take    = s_axi_wvalid & wready_q;
	wire commit    = aw_full_q & w_full_q & ~bvalid_q;
	wire aw_full_d = aw_take | (aw_full_q & ~commit);
	wire w_full_d  = w_take | (w_full_q & ~commit);
	wire w_map     = (aw_addr_q == `DMZ_A_MODE) | (aw_addr_q == `DMZ_A_CTRL) |
	                 (aw_addr_q == `DMZ_A_STAT) | (aw_addr_q == `DMZ_A_LAT);
	wire ctrl_wr   = commit & (aw_addr_q == `DMZ_A_CTRL) & w_strb0_q;

	wire ar_take   = s_axi_arvalid & arready_q;
	wire rvalid_d  = ar_take | (rvalid_q & ~s_axi_rready);
	wire [31:0] stat_word = {26'h0, dll_run_q, recov_q != 5'h00, exit_q != 5'h00,
	                         pd_q, lock_q != 10'h000, mode_q[`DMZ_DLLRST_BIT]};
	wire [31:0] lat_word  = {19'h0, wr_cyc, 3'h0, rl_total};
	wire r_mode = (s_axi_araddr == `DMZ_A_MODE);
	wire r_ctrl = (s_axi_araddr == `DMZ_A_CTRL);
	wire r_stat = (s_axi_araddr == `DMZ_A_STAT);
	wire r_lat  = (s_axi_araddr == `DMZ_A_LAT);
	wire [31:0] rd_word = r_mode ? {19'h0, mode_q} : r_ctrl ? {30'h0, ctrl_q} :
	                      r_stat ? stat_word : r_lat ? lat_word : 32'h0;

	always_ff @(posedge clk) begin
		if (rst) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end else begin
			awready_q <= ~aw_full_d;
			wready_q  <= ~w_full_d;
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			bvalid_q  <= commit | (bvalid_q & ~s_axi_bready);
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_addr_q <= 4'h0;
			w_data_q  <= 32'h0;
			w_strb0_q <= 1'b0;
			bresp_q   <= `DMZ_RESP_OK;
			rresp_q   <= `DMZ_RESP_OK;
			rdata_q   <= 32'h0;
			ctrl_q    <= `DMZ_CTRL_RST;
		end else begin
			if (aw_take)
				aw_addr_q <= s_axi_awaddr;
			if (w_take) begin
				w_data_q  <= s_axi_wdata;
				w_strb0_q <= s_axi_wstrb[0];
			end
			if (commit)
				bresp_q <= w_map ? `DMZ_RESP_OK : `DMZ_RESP_ERR;
			if (ctrl_wr)
				ctrl_q <= w_data_q[1:0];
			if (ar_take) begin
				rdata_q <= rd_word;
				rresp_q <= (r_mode | r_ctrl | r_stat | r_lat) ? `DMZ_RESP_OK : `DMZ_RESP_ERR;
			end
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign dq_out        = dq_out_q;
	assign dq_oe_n       = dq_oe_n_q;
	assign dqs_out       = dqs_out_q;
	assign dqs_oe_n      = dq_oe_n_q;
	assign dll_run       = dll_run_q;

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_order_seq: assert property (!bt_intlv && !chop_q |->
		ord_idx == {col_q[2] ^ nb[2], 2'(col_q[1:0] + nb[1:0])}) else $error("sequential order wrong");
	a_order_int: assert property (bt_intlv && !chop_q |-> ord_idx == (col_q ^ nb))
		else $error("interleaved order wrong");
	a_chop_release: assert property (ck_rise && st_rdb && chop_q && beat_q == 3'h3 |=>
		dq_oe_n_q [*4]) else $error("chop slot driven");
	a_first_beat: assert property (enter_rd |=> !dq_oe_n_q && st_rdb)
		else $error("first read beat missing");
	a_latency_load: assert property (take_rd |=> lat_q == $past(rl_total))
		else $error("read latency not loaded");
	a_fixed_len: assert property (take_rd && bl_field == `DMZ_BL_FIX8 |=> !chop_q)
		else $error("fixed eight chopped");
	a_otf_select: assert property (take_wr && bl_otf |=> chop_q == !$past(a_s[`DMZ_BC_BIT]))
		else $error("chop select ignored");
	a_chop_store: assert property (store && chop_q |-> wr_idx[2] == col_q[2] && !nb[2])
		else $error("chop write group wrong");
	a_early_start: assert property (wr_start && fix_q |-> nb == 3'h5)
		else $error("fixed chop start wrong");
	a_late_start: assert property (wr_start && !fix_q |-> nb == 3'h7)
		else $error("write start pulled in");
	a_dll_clear: assert property (dll_clear && !take_mrs |=> !mode_q[`DMZ_DLLRST_BIT] &&
		lock_q == `DMZ_LOCK_CYC) else $error("loop reset bit stuck");
	a_dal_load: assert property (wr_start |=> recov_q == $past(wr_cyc) + ($past(ap_q) ? 5'h01 : 5'h00))
		else $error("recovery interval wrong");
	a_pd_freeze: assert property (pd_enter |=> dll_run_q == $past(fast) && pd_q)
		else $error("loop state in power-down wrong");
	a_pd_exit: assert property (pd_exit |=> dll_run_q && exit_q == ($past(fast) ? 5'h03 : 5'h0A))
		else $error("exit delay wrong");

	c_read_chop: cover property (enter_rd && chop_q);
	c_read_eight: cover property (ck_rise && st_rdb && beat_end && !chop_q);
	c_write_auto: cover property (wr_start && ap_q);
	c_power_down: cover property (pd_exit && !fast);
endmodule

// file: test/dmz_ctl_model.sv
// controller model: link clock, command strobes and write data
`timescale 1ns/1ps
module dmz_ctl_model (
	// link clock and command pins
	output logic        ck,
	output logic        cke,
	output logic        cs_n,
	output logic        ras_n,
	output logic        cas_n,
	output logic        we_n,
	output logic [2:0]  ba,
	output logic [12:0] addr,
	// write data pins
	output logic [7:0]  dq_in
);
	// ----
	// link clock
	// ----
	// offset keeps link edges off the block clock edges
	initial begin
		{ck, cke, cs_n, ras_n, cas_n, we_n} = 6'h1F;
		ba = 3'h7;
		addr = 13'h0000;
		dq_in = 8'hA5;
		#13;
		forever #200 ck = ~ck;
	end
	// ----
	// commands
	// ----
	// strobes and bank bits, issued only while idle
	task automatic cmd(input logic [3:0] code, input logic [12:0] a);
		@(negedge ck);
		{cs_n, ras_n, cas_n, we_n} <= code;
		ba <= 3'h0;
		addr <= a & 13'h1F7F;
		@(negedge ck);
		{cs_n, ras_n, cas_n, we_n} <= 4'hF;
		ba <= 3'h7;
		addr <= ~a;
	endtask
	// bytes on edges 5 to 12, idle lines keep toggling
	task automatic wr(input logic [12:0] a, input logic [63:0] d);
		cmd(4'h4, a);
		for (int e = 1; e < 13; e++) begin
			dq_in <= (e >= 5) ? d[8 * (e - 5) +: 8] : ~dq_in;
			@(negedge ck);
		end
		dq_in <= ~dq_in;
		repeat (16) @(negedge ck);
	endtask
	// each state held past the exit delay
	task automatic power(input logic on);
		@(negedge ck);
		cke <= on;
		repeat (12) @(negedge ck);
	endtask
endmodule

// file: test/dram_mode_zero_burst_latency_bench.sv
// self-checking bench for the mode register zero burst and latency block
`timescale 1ns/1ps
`define CHK(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); \
	end \
end
module dram_mode_zero_burst_latency_bench;
	logic        clk, rst, ck, cke, cs_n, ras_n, cas_n, we_n, dq_oe_n, dqs_out, dqs_oe_n, dll_run;
	logic [2:0]  ba;
	logic [12:0] addr;
	logic [7:0]  dq_in, dq_out;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  mem [8];
	logic [63:0] d;
	int          n_fail, n_checks;
	int unsigned seed_v;

	dmz_core dmz_core_i (.*);
	dmz_ctl_model dmz_ctl_model_i (.*);

	// ----
	// clock and watchdog
	// ----
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		#2000000;
		n_fail++;
		summarize();
	end

	// ----
	// tasks
	// ----
	task automatic summarize;
		if (n_fail == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
		@(posedge clk);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {3'h7, a, v};
		do begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bready <= 1'h0;
				`CHK(s_axi_bresp, r)
			end
		end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
		@(posedge clk);
		{s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
		do begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rready <= 1'h0;
				`CHK({s_axi_rresp, s_axi_rdata}, {r, v})
			end
		end while (s_axi_arvalid || s_axi_rready);
	endtask
	// column of read beat k from start column and burst type
	function automatic logic [2:0] order_of(input logic [2:0] c, input logic il, input int k);
		return il ? c ^ 3'(k) : {c[2] ^ k[2], 2'(c[1:0] + 2'(k))};
	endfunction
	// beat k is looked at one link edge after it was launched
	task automatic rd(input logic [2:0] c, input logic bc, input logic il, input logic chop, input int rl);
		logic [2:0] w;
		dmz_ctl_model_i.cmd(4'h5, {bc, 9'h000, c});
		repeat (rl) @(posedge ck);
		for (int k = 0; k < 8; k++) begin
			@(posedge ck);
			w = order_of(c, il, k);
			if (!chop || k < 4)
				`CHK({dq_oe_n, dqs_oe_n, dqs_out, dq_out}, {2'h0, ~k[0], mem[w]})
			else
				`CHK({dq_oe_n, dqs_oe_n}, 2'h3)
		end
		@(posedge ck);
		`CHK(dq_oe_n, 1'h1)
	endtask

	// ----
	// scenarios
	// ----
	initial begin
		seed_v = $urandom(32'h0801);
		{rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {8'h00, 4'hF, 32'h0};
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		`CHK({dq_oe_n, dqs_oe_n, dll_run}, 3'h7)
		axi_rd(4'h0, 32'h0, 2'h0);
		dmz_ctl_model_i.cmd(4'h0, 13'h0220);
		axi_rd(4'h0, 32'h0220, 2'h0);
		axi_rd(4'hC, 32'h0506, 2'h0);
		d = {$urandom, $urandom};
		dmz_ctl_model_i.wr(13'h0007, d);
		for (int i = 0; i < 8; i++)
			mem[i] = d[8 * i +: 8];
		for (int m = 0; m < 4; m++) begin
			dmz_ctl_model_i.cmd(4'h0, 13'h0220 | {9'h0, m[0], 1'h0, m[1], 1'h0});
			for (int s = 0; s < 8; s++)
				rd(s[2:0], 1'h0, m[0], m[1], 6);
		end
		d = {$urandom, $urandom};
		dmz_ctl_model_i.wr(13'h0004, d);
		for (int i = 0; i < 4; i++)
			mem[4 + i] = d[8 * i +: 8];
		dmz_ctl_model_i.cmd(4'h0, 13'h0221);
		d = {$urandom, $urandom};
		// per-command chop write with auto-precharge, group zero
		dmz_ctl_model_i.wr(13'h0400, d);
		for (int i = 0; i < 4; i++)
			mem[i] = d[8 * i +: 8];
		rd(3'($urandom), 1'h1, 1'h0, 1'h0, 6);
		rd(3'($urandom), 1'h0, 1'h0, 1'h1, 6);
		axi_wr(4'h4, 32'h1, 2'h0);
		axi_rd(4'h4, 32'h1, 2'h0);
		axi_rd(4'hC, 32'h050B, 2'h0);
		rd(3'h5, 1'h1, 1'h0, 1'h0, 11);
		axi_rd(4'h6, 32'h0, 2'h2);
		axi_wr(4'h6, 32'h0, 2'h2);
		for (int f = 0; f < 2; f++) begin
			dmz_ctl_model_i.cmd(4'h0, {f[0], 12'h221});
			dmz_ctl_model_i.power(1'h0);
			`CHK(dll_run, f[0])
			axi_rd(4'h8, {26'h0, f[0], 5'h04}, 2'h0);
			dmz_ctl_model_i.power(1'h1);
			`CHK(dll_run, 1'h1)
		end
		axi_wr(4'h0, 32'h1FFF, 2'h0);
		dmz_ctl_model_i.cmd(4'h0, 13'h0320);
		repeat (2) @(negedge ck);
		axi_rd(4'h0, 32'h0220, 2'h0);
		axi_rd(4'h8, 32'h22, 2'h0);
		repeat (520) @(negedge ck);
		axi_rd(4'h8, 32'h20, 2'h0);
		summarize();
	end
endmodule
